// >>> rtl/mcft_exc_unit.sv
// What this block does
// RULE1 - Vectors 5,6,7 for divide, check, trap
// RULE2 - User-mode privileged instruction raises vector 8
// RULE3 - Opcode 1010b vector 10, 1111b vector 11
// RULE4 - Trap 32 plus operand, extended trap 96-111
// RULE5 - Bad return frame version raises vector 14
// RULE6 - Trace bits: off, flow, instruction, reserved
// RULE7 - Flow trace on non-sequential program counter
// RULE8 - Instruction trace only on completed instructions
// RULE9 - Forced, then trace, then interrupt, breakpoint; irq_pending is ignored, so hw_break follows trace
// RULE10 - Traced halt instruction traces, does not stop
// RULE11 - Trace uses vector 9, instruction-error frame
// RULE12 - Break instruction or hardware trigger vector 12
// RULE13 - Overtime vector 64, mode picks target context
// RULE14 - Standard-mode overtime uses short frame
// RULE15 - Protection denial raises vector 65
// RULE16 - Protection fault only on performed access
// RULE17 - Access to nonexistent mapped memory is fatal
// RULE18 - Fatal in contexts 1-4: halt, record, vector 95
// RULE19 - Fatal in master context halts whole processor
// RULE20 - Double faults and stacking faults are fatal
// RULE21 - Fault-origin register: low byte RW, resets zero
// RULE22 - Entry sets supervisor, clears both trace bits
// RULE23 - Table address is base plus vector times four
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ns
module mcft_exc_unit #(
  parameter int CTX_W = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_done,
  input wire logic [15:0] opcode,
  input wire logic [3:0] trap_operand,
  input wire logic user_mode,
  input wire logic priv_instr,
  input wire logic div_zero,
  input wire logic check_fail,
  input wire logic cond_trap_taken,
  input wire logic trap_instr,
  input wire logic trapx_instr,
  input wire logic soft_break_opcode,
  input wire logic ret_check,
  input wire logic ret_version_ok,
  input wire logic ret_format_ok,
  input wire logic instr_trace_bit,
  input wire logic flow_trace_bit,
  input wire logic flow_change,
  input wire logic instr_aborted,
  input wire logic halt_instr,
  input wire logic low_power_halt_instr,
  input wire logic irq_pending,
  input wire logic hw_break,
  input wire logic ctx_timer_expired,
  input wire logic ctx_standard_mode,
  input wire logic access_performed,
  input wire logic fetch_will_exec,
  input wire logic access_stalled,
  input wire logic prot_unassigned,
  input wire logic prot_write_ro,
  input wire logic prot_disabled,
  input wire logic mem_nonexistent,
  input wire logic reset_vec_bus_err,
  input wire logic bus_fault,
  input wire logic addr_fault,
  input wire logic in_exception_stack,
  input wire logic [CTX_W-1:0] cur_ctx,
  input wire logic [31:0] vector_table_base,
  output logic exc_take,
  output logic [7:0] exc_vector,
  output logic [1:0] exc_frame,
  output logic [CTX_W-1:0] exc_ctx,
  output logic [31:0] exc_table_addr,
  output logic set_supervisor,
  output logic clear_trace,
  output logic ctx_halt,
  output logic [CTX_W-1:0] ctx_halt_id,
  output logic cpu_halted,
  output logic halt_suppressed
);

  logic [7:0] fault_origin_q;
  logic [31:0] ctrl_q;
  logic cpu_halted_q;
  logic [1:0] fault_depth_q;
  logic trace_deferred_q;
  logic [7:0] last_vec_q;
  logic apb_acc;
  logic wr_en;
  logic forced;
  logic [7:0] forced_vec;
  logic [1:0] forced_frame;
  logic trace_hit;
  logic prot_hit;
  logic fatal;
  logic [7:0] vec_d;
  logic [1:0] frame_d;
  logic [CTX_W-1:0] ctx_d;
  logic take_d;
  logic any_fault;
  logic ovt_halt;

  function automatic logic [31:0] table_addr(input logic [31:0] base, input logic [7:0] vec);
    table_addr = base + {22'h000000, vec, 2'h0}; // RULE23
  endfunction

  // Context 0 is the master; its fatal faults have nowhere to escalate
  function automatic logic is_master(input logic [CTX_W-1:0] ctx);
    is_master = (ctx == CTX_W'(mcft_pkg::MASTER_CTX));
  endfunction

  assign apb_acc = psel && penable;
  assign wr_en = apb_acc && pwrite;

  assign any_fault = bus_fault || addr_fault || prot_hit;

  // Fatal classes: reset-vector fetch, nonexistent memory, second fault, fault while stacking
  assign fatal = reset_vec_bus_err || mem_nonexistent && access_performed // RULE17
    || any_fault && (fault_depth_q != 2'h0 || in_exception_stack); // RULE20

  // Standard-mode overtime halts the offender and records it
  assign ovt_halt = ctx_timer_expired && ctx_standard_mode && take_d
    && vec_d == mcft_pkg::VEC_OVERTIME; // RULE13

  // Only a performed access faults; a stalled one waits for its retry
  assign prot_hit = access_performed && !access_stalled && fetch_will_exec && !mem_nonexistent
    && (prot_unassigned || prot_write_ro || prot_disabled); // RULE15 RULE16

  always_comb begin
    forced = 1'b1;
    forced_vec = mcft_pkg::VEC_DIV_ZERO;
    forced_frame = mcft_pkg::FRAME_INSTR_ERR;
    if (div_zero) begin
      forced_vec = mcft_pkg::VEC_DIV_ZERO; // RULE1
    end else if (check_fail) begin
      forced_vec = mcft_pkg::VEC_CHECK; // RULE1
    end else if (cond_trap_taken) begin
      forced_vec = mcft_pkg::VEC_COND_TRAP; // RULE1
    end else if (priv_instr && user_mode) begin
      forced_vec = mcft_pkg::VEC_PRIV; // RULE2
      forced_frame = mcft_pkg::FRAME_SHORT;
    end else if (opcode[15:12] == mcft_pkg::OPC_ALINE) begin
      forced_vec = mcft_pkg::VEC_ALINE; // RULE3
      forced_frame = mcft_pkg::FRAME_SHORT;
    end else if (opcode[15:12] == mcft_pkg::OPC_FLINE) begin
      forced_vec = mcft_pkg::VEC_FLINE; // RULE3
      forced_frame = mcft_pkg::FRAME_SHORT;
    end else if (trap_instr) begin
      forced_vec = mcft_pkg::VEC_TRAP_BASE | {4'h0, trap_operand}; // RULE4
      forced_frame = mcft_pkg::FRAME_SHORT;
    end else if (trapx_instr) begin
      forced_vec = mcft_pkg::VEC_TRAPX_BASE | {4'h0, trap_operand}; // RULE4
      forced_frame = mcft_pkg::FRAME_SHORT;
    end else if (ret_check && !(ret_version_ok && ret_format_ok)) begin
      forced_vec = mcft_pkg::VEC_FORMAT; // RULE5
      forced_frame = mcft_pkg::FRAME_SHORT;
    end else if (soft_break_opcode && ctrl_q[mcft_pkg::CTRL_SOFT_BREAK_EN]) begin
      forced_vec = mcft_pkg::VEC_BREAK; // RULE12
    end else begin
      forced = 1'b0;
    end
  end

  // Off and reserved codes trace only an owed trace; an owed trace waits for a clean completion
  always_comb begin
    trace_hit = trace_deferred_q && instr_done && !instr_aborted; // RULE8
    unique case ({instr_trace_bit, flow_trace_bit}) // RULE6
      mcft_pkg::TRACE_FLOW: trace_hit = instr_done && flow_change; // RULE7
      mcft_pkg::TRACE_INSTR: trace_hit = instr_done && !instr_aborted; // RULE8
      default: trace_hit = trace_deferred_q && instr_done && !instr_aborted;
    endcase
  end

  always_comb begin
    take_d = 1'b1;
    vec_d = mcft_pkg::VEC_INTER_CTX;
    frame_d = mcft_pkg::FRAME_SHORT;
    ctx_d = cur_ctx;
    if (cpu_halted_q) begin
      take_d = 1'b0;
    end else if (fatal) begin
      ctx_d = CTX_W'(mcft_pkg::MASTER_CTX); // RULE18
      take_d = !is_master(cur_ctx); // RULE19
    end else if (prot_hit) begin
      vec_d = mcft_pkg::VEC_PROT; // RULE15
      frame_d = mcft_pkg::FRAME_INSTR_ERR;
    end else if (bus_fault || addr_fault) begin
      vec_d = bus_fault ? mcft_pkg::VEC_BUS_ERR : mcft_pkg::VEC_ADDR_ERR;
      frame_d = mcft_pkg::FRAME_INSTR_ERR;
    end else if (forced && instr_done) begin
      vec_d = forced_vec; // RULE9
      frame_d = forced_frame;
    end else if (trace_hit) begin
      vec_d = mcft_pkg::VEC_TRACE; // RULE11 RULE9
      frame_d = mcft_pkg::FRAME_INSTR_ERR;
    end else if (hw_break) begin
      vec_d = mcft_pkg::VEC_BREAK; // RULE12
      frame_d = mcft_pkg::FRAME_INSTR_ERR;
    end else if (ctx_timer_expired) begin
      vec_d = mcft_pkg::VEC_OVERTIME; // RULE13
      frame_d = ctx_standard_mode ? mcft_pkg::FRAME_SHORT : mcft_pkg::FRAME_NONE; // RULE14
      ctx_d = ctx_standard_mode ? CTX_W'(mcft_pkg::MASTER_CTX) : cur_ctx; // RULE13
    end else begin
      take_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_take <= 1'b0;
      exc_vector <= 8'h00;
      exc_frame <= 2'h0;
      exc_ctx <= '0;
    end else begin
      exc_take <= take_d;
      exc_vector <= vec_d;
      exc_frame <= frame_d;
      exc_ctx <= ctx_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_table_addr <= 32'h0000_0000;
    end else begin
      exc_table_addr <= table_addr(vector_table_base, vec_d); // RULE23
    end
  end

  // Handler entry state travels with every take; a trace owed by an abort in the take's own cycle still fires in the handler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_supervisor <= 1'b0;
      clear_trace <= 1'b0;
    end else begin
      set_supervisor <= take_d; // RULE22
      clear_trace <= take_d; // RULE22
    end
  end

  // Fault depth counts nesting until the handler retires without a new fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_depth_q <= 2'h0;
    end else if (take_d && any_fault && fault_depth_q != 2'h3) begin
      fault_depth_q <= fault_depth_q + 2'h1;
    end else if (instr_done && !take_d) begin
      fault_depth_q <= 2'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trace_deferred_q <= 1'b0;
    end else if (instr_trace_bit && !flow_trace_bit && instr_aborted) begin
      trace_deferred_q <= 1'b1; // RULE8
    end else if (take_d) begin
      trace_deferred_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_suppressed <= 1'b0;
    end else begin
      halt_suppressed <= (halt_instr || low_power_halt_instr) && instr_done
        && instr_trace_bit && !flow_trace_bit; // RULE10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctx_halt <= 1'b0;
      ctx_halt_id <= '0;
    end else begin
      ctx_halt <= 1'b0;
      if (!cpu_halted_q && fatal && !is_master(cur_ctx)) begin
        ctx_halt <= 1'b1; // RULE18
        ctx_halt_id <= cur_ctx;
      end else if (!cpu_halted_q && ovt_halt) begin
        ctx_halt <= 1'b1; // RULE13
        ctx_halt_id <= cur_ctx;
      end
    end
  end

  // Only reset leaves the halted state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_halted_q <= 1'b0;
    end else if (fatal && is_master(cur_ctx)) begin
      cpu_halted_q <= 1'b1; // RULE19
    end
  end

  assign cpu_halted = cpu_halted_q;

  // Hardware record wins over a same-cycle software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_origin_q <= mcft_pkg::FAULT_ORIGIN_RESET[7:0]; // RULE21
    end else if (!cpu_halted_q && (fatal || ovt_halt) && !is_master(cur_ctx)) begin
      fault_origin_q <= 8'(cur_ctx); // RULE18 RULE13
    end else if (wr_en && paddr == mcft_pkg::ADDR_FAULT_ORIGIN && pstrb[0]) begin
      fault_origin_q <= pwdata[7:0]; // RULE21
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 32'h0000_0000;
    end else if (wr_en && paddr == mcft_pkg::ADDR_CTRL && pstrb[0]) begin
      ctrl_q <= {31'h0000_0000, pwdata[mcft_pkg::CTRL_SOFT_BREAK_EN]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_vec_q <= 8'h00;
    end else if (take_d) begin
      last_vec_q <= vec_d;
    end
  end

  // Zero-wait slave; read data registered in setup so it is stable in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        unique case (paddr)
          mcft_pkg::ADDR_FAULT_ORIGIN: begin
            prdata <= {24'h000000, fault_origin_q}; // RULE21
          end
          mcft_pkg::ADDR_CTRL: begin
            prdata <= ctrl_q;
          end
          mcft_pkg::ADDR_STATUS: begin
            prdata <= {30'h0, fault_depth_q != 2'h0, cpu_halted_q};
          end
          mcft_pkg::ADDR_LAST_VEC: begin
            prdata <= {24'h000000, last_vec_q};
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule // mcft_exc_unit

// >>> rtl/mcft_pkg.sv
package mcft_pkg;
  localparam logic [7:0] VEC_BUS_ERR = 8'h02;
  localparam logic [7:0] VEC_ADDR_ERR = 8'h03;
  localparam logic [7:0] VEC_DIV_ZERO = 8'h05;
  localparam logic [7:0] VEC_CHECK = 8'h06;
  localparam logic [7:0] VEC_COND_TRAP = 8'h07;
  localparam logic [7:0] VEC_PRIV = 8'h08;
  localparam logic [7:0] VEC_TRACE = 8'h09;
  localparam logic [7:0] VEC_ALINE = 8'h0A;
  localparam logic [7:0] VEC_FLINE = 8'h0B;
  localparam logic [7:0] VEC_BREAK = 8'h0C;
  localparam logic [7:0] VEC_FORMAT = 8'h0E;
  localparam logic [7:0] VEC_TRAP_BASE = 8'h20;
  localparam logic [7:0] VEC_OVERTIME = 8'h40;
  localparam logic [7:0] VEC_PROT = 8'h41;
  localparam logic [7:0] VEC_INTER_CTX = 8'h5F;
  localparam logic [7:0] VEC_TRAPX_BASE = 8'h60;
  localparam logic [3:0] OPC_ALINE = 4'hA;
  localparam logic [3:0] OPC_FLINE = 4'hF;
  localparam logic [1:0] TRACE_OFF = 2'h0;
  localparam logic [1:0] TRACE_FLOW = 2'h1;
  localparam logic [1:0] TRACE_INSTR = 2'h2;
  localparam logic [1:0] FRAME_SHORT = 2'h0;
  localparam logic [1:0] FRAME_INSTR_ERR = 2'h1;
  localparam logic [1:0] FRAME_NONE = 2'h2;
  localparam logic [11:0] ADDR_FAULT_ORIGIN = 12'h000;
  localparam logic [11:0] ADDR_CTRL = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_LAST_VEC = 12'h00C;
  localparam logic [31:0] FAULT_ORIGIN_RESET = 32'h0000_0000;
  localparam int CTRL_SOFT_BREAK_EN = 0;
  localparam logic [2:0] MASTER_CTX = 3'h0;
  localparam logic [2:0] MAX_CTX = 3'h4;
endpackage

// >>> verif/mcft_exc_unit_props.sv
`timescale 1ns/1ns
module mcft_exc_unit_props #(
  parameter int CTX_W = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic instr_done,
  input wire logic instr_aborted,
  input wire logic bus_fault,
  input wire logic in_exception_stack,
  input wire logic [CTX_W-1:0] cur_ctx,
  input wire logic [31:0] vector_table_base,
  input wire logic exc_take,
  input wire logic [7:0] exc_vector,
  input wire logic [1:0] exc_frame,
  input wire logic [CTX_W-1:0] exc_ctx,
  input wire logic [31:0] exc_table_addr,
  input wire logic set_supervisor,
  input wire logic clear_trace,
  input wire logic ctx_halt,
  input wire logic [CTX_W-1:0] ctx_halt_id,
  input wire logic cpu_halted
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Stacking bus fault is the cheapest fatal cause to watch
  wire fatal = bus_fault && in_exception_stack;
  a_entry_bits: assert property (exc_take |-> set_supervisor && clear_trace)
    else $error("entry kept user or trace state");
  a_table_addr: assert property (exc_take |->
    exc_table_addr == $past(vector_table_base) + {22'h0, exc_vector, 2'h0})
    else $error("bad table address");
  a_trace_done: assert property (exc_take && exc_vector == 8'h09 |->
    $past(instr_done) && !$past(instr_aborted)) else $error("trace without completion");
  a_err_frame: assert property (exc_take &&
    exc_vector inside {8'h05, 8'h06, 8'h07, 8'h09, 8'h0C, 8'h41} |-> exc_frame == 2'h1)
    else $error("expected error frame");
  a_short_frame: assert property (exc_take &&
    (exc_vector inside {8'h08, 8'h0A, 8'h0B, 8'h0E} || exc_vector[7:4] inside {4'h2, 4'h6})
    |-> exc_frame == 2'h0) else $error("expected short frame");
  a_halt_pair: assert property (ctx_halt |->
    exc_take && exc_ctx == '0 && ctx_halt_id != '0) else $error("halt not sent to master");
  a_fatal_ctx: assert property (fatal && cur_ctx != '0 && !cpu_halted |=>
    ctx_halt && ctx_halt_id == $past(cur_ctx) && exc_vector == 8'h5F)
    else $error("fatal fault not escalated");
  a_master_stop: assert property (fatal && cur_ctx == '0 |=> cpu_halted && !exc_take)
    else $error("master fatal did not stop");
  a_halt_sticky: assert property (cpu_halted |=> cpu_halted && !exc_take && !ctx_halt)
    else $error("halted core moved");
  cover property (exc_take && exc_vector == 8'h09);
  cover property (ctx_halt);
  cover property (cpu_halted);
endmodule // mcft_exc_unit_props
bind mcft_exc_unit mcft_exc_unit_props #(.CTX_W(CTX_W)) u_props (.pclk, .presetn,
  .instr_done, .instr_aborted, .bus_fault, .in_exception_stack, .cur_ctx,
  .vector_table_base, .exc_take, .exc_vector, .exc_frame, .exc_ctx, .exc_table_addr,
  .set_supervisor, .clear_trace, .ctx_halt, .ctx_halt_id, .cpu_halted);

// >>> verif/mcft_exc_unit_tb.sv
`timescale 1ns/1ns
module mcft_exc_unit_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, exc_table_addr, r;
  logic [31:0] vb = 32'h0002_0000;
  logic pready, pslverr, e, exc_take, set_supervisor, clear_trace, ctx_halt;
  logic cpu_halted, halt_suppressed;
  logic [25:0] c = 26'h0;
  logic [15:0] op = 16'h4E71;
  logic [3:0] tn = 4'h0;
  logic [2:0] cx = 3'h1;
  logic [2:0] ld_val = 3'h0;
  logic [2:0] st, exc_ctx, ctx_halt_id;
  logic [7:0] exc_vector;
  logic [1:0] exc_frame;
  logic sm = 1'b0;
  logic ld = 1'b0;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  initial forever #20 pclk = ~pclk;
  mcft_exc_unit #(.CTX_W(3)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .instr_done(c[0]), .opcode(op),
    .trap_operand(tn), .user_mode(st[2]), .priv_instr(c[4]), .div_zero(c[1]),
    .check_fail(c[2]), .cond_trap_taken(c[3]), .trap_instr(c[5]), .trapx_instr(c[6]),
    .soft_break_opcode(c[7]), .ret_check(c[8]), .ret_version_ok(1'b1),
    .ret_format_ok(~c[25]), .instr_trace_bit(st[1]), .flow_trace_bit(st[0]),
    .flow_change(c[9]), .instr_aborted(c[10]), .halt_instr(c[11]),
    .low_power_halt_instr(c[22]), .irq_pending(1'b0), .hw_break(c[12]),
    .ctx_timer_expired(c[13]), .ctx_standard_mode(sm), .access_performed(c[14]),
    .fetch_will_exec(1'b1), .access_stalled(c[15]), .prot_unassigned(c[20]),
    .prot_write_ro(c[16]), .prot_disabled(c[21]), .mem_nonexistent(c[17]),
    .reset_vec_bus_err(c[24]), .bus_fault(c[18]), .addr_fault(c[23]),
    .in_exception_stack(c[19]), .cur_ctx(cx), .vector_table_base(vb), .exc_take,
    .exc_vector, .exc_frame, .exc_ctx, .exc_table_addr, .set_supervisor, .clear_trace,
    .ctx_halt, .ctx_halt_id, .cpu_halted, .halt_suppressed);
  mcft_pipe_model u_pipe (.pclk, .presetn, .ld, .ld_val, .set_supervisor, .clear_trace, .st);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task rst;
    @(posedge pclk) presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // Zero wait states, but the wait loop still follows pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk) psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task setst(input logic [2:0] v);
    @(posedge pclk) ld <= 1'b1;
    ld_val <= v;
    @(posedge pclk) ld <= 1'b0;
  endtask
  // One-cycle cause, judged while the registered answer stands
  task ev(input logic [25:0] v, input logic [7:0] ve, input logic [1:0] fr, input logic tk);
    @(posedge pclk) c <= v;
    @(posedge pclk) c <= 26'h0;
    #1;
    chk(32'(exc_take), 32'(tk));
    if (tk) begin
      chk(32'(exc_vector), 32'(ve));
      if (fr != 2'h3) chk(32'(exc_frame), 32'(fr));
      chk(exc_table_addr, vb + {22'h0, ve, 2'h0});
      chk(32'(set_supervisor & clear_trace), 32'h1);
    end
  endtask
  task t_regs;
    apb(1'b0, 12'h000, 32'h0);
    chk(r, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'hFFFF_FF03);
    apb(1'b0, 12'h000, 32'h0);
    chk(r, 32'h0000_0003);
    apb(1'b0, 12'hFF0, 32'h0);
    chk(32'(e), 32'h1);
    ev(26'h81, 8'h00, 2'h0, 1'b0);
    apb(1'b1, 12'h004, 32'h1);
  endtask
  task t_forced;
    ev(26'h3, 8'h05, 2'h1, 1'b1);
    ev(26'h5, 8'h06, 2'h1, 1'b1);
    ev(26'h9, 8'h07, 2'h1, 1'b1);
    setst(3'h4);
    ev(26'h11, 8'h08, 2'h0, 1'b1);
    ev(26'h11, 8'h00, 2'h0, 1'b0);
    @(posedge pclk) tn <= 4'hF;
    ev(26'h21, 8'h2F, 2'h0, 1'b1);
    ev(26'h41, 8'h6F, 2'h0, 1'b1);
    ev(26'h81, 8'h0C, 2'h1, 1'b1);
    ev(26'h1000, 8'h0C, 2'h1, 1'b1);
    ev(26'h2000101, 8'h0E, 2'h0, 1'b1);
    ev(26'h101, 8'h00, 2'h0, 1'b0);
    @(posedge pclk) op <= 16'hA000;
    ev(26'h1, 8'h0A, 2'h0, 1'b1);
    @(posedge pclk) op <= 16'hF000;
    ev(26'h1, 8'h0B, 2'h0, 1'b1);
    @(posedge pclk) op <= 16'h4E71;
  endtask
  task t_trace;
    setst(3'h2);
    ev(26'h1001, 8'h09, 2'h1, 1'b1);
    ev(26'h1, 8'h00, 2'h0, 1'b0);
    setst(3'h2);
    ev(26'h401, 8'h00, 2'h0, 1'b0);
    ev(26'h1, 8'h09, 2'h1, 1'b1);
    setst(3'h2);
    ev(26'h3, 8'h05, 2'h1, 1'b1);
    setst(3'h2);
    ev(26'h801, 8'h09, 2'h1, 1'b1);
    chk(32'(halt_suppressed), 32'h1);
    setst(3'h2);
    ev(26'h400001, 8'h09, 2'h1, 1'b1);
    chk(32'(halt_suppressed), 32'h1);
    setst(3'h1);
    ev(26'h1, 8'h00, 2'h0, 1'b0);
    ev(26'h201, 8'h09, 2'h1, 1'b1);
    ev(26'h201, 8'h00, 2'h0, 1'b0);
  endtask
  task t_prot;
    @(posedge pclk) cx <= 3'h2;
    ev(26'h14000, 8'h41, 2'h1, 1'b1);
    ev(26'h1, 8'h00, 2'h0, 1'b0);
    ev(26'h104000, 8'h41, 2'h1, 1'b1);
    ev(26'h1, 8'h00, 2'h0, 1'b0);
    ev(26'h204000, 8'h41, 2'h1, 1'b1);
    ev(26'h1C000, 8'h00, 2'h0, 1'b0);
    ev(26'h10000, 8'h00, 2'h0, 1'b0);
    ev(26'h24000, 8'h5F, 2'h3, 1'b1);
    chk(32'(ctx_halt_id), 32'h2);
  endtask
  task t_ovt;
    @(posedge pclk) cx <= 3'h3;
    sm <= 1'b1;
    ev(26'h2000, 8'h40, 2'h0, 1'b1);
    chk(32'(exc_ctx), 32'h0);
    chk(32'(ctx_halt), 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk(r, 32'h0000_0003);
    @(posedge pclk) sm <= 1'b0;
    ev(26'h2000, 8'h40, 2'h2, 1'b1);
    chk(32'(exc_ctx), 32'h3);
  endtask
  task t_fatal;
    @(posedge pclk) cx <= 3'h4;
    ev(26'hC0000, 8'h5F, 2'h3, 1'b1);
    chk(32'(exc_ctx), 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(r, 32'h0000_0004);
    ev(26'h880000, 8'h5F, 2'h3, 1'b1);
    @(posedge pclk) cx <= 3'h0;
    ev(26'hC0000, 8'h00, 2'h0, 1'b0);
    chk(32'(cpu_halted), 32'h1);
    ev(26'h3, 8'h00, 2'h0, 1'b0);
    rst;
    chk(32'(cpu_halted), 32'h0);
  endtask
  initial begin
    rst;
    t_regs;
    t_forced;
    t_trace;
    t_prot;
    t_ovt;
    t_fatal;
    finish_test;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      finish_test;
    end
  end
endmodule // mcft_exc_unit_tb

// >>> verif/mcft_pipe_model.sv
`timescale 1ns/1ns
module mcft_pipe_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ld,
  input wire logic [2:0] ld_val,
  input wire logic set_supervisor,
  input wire logic clear_trace,
  output logic [2:0] st
);
  // Status word: user mode, instruction trace, flow trace
  logic [2:0] st_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= 3'h0;
    end else if (ld) begin
      st_q <= ld_val;
    end else begin
      if (set_supervisor) st_q[2] <= 1'b0;
      if (clear_trace) st_q[1:0] <= 2'h0;
    end
  end
  assign st = st_q;
endmodule // mcft_pipe_model
